/* rtl/tthp_host_pins.sv */
`timescale 1ns/10ps
module tthp_host_pins (
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	input  wire logic       split_strobe_mode_i,
	input  wire logic       chip_sel_n_i,
	input  wire logic       register_select_i,
	input  wire logic       rw_or_write_n_i,
	input  wire logic       data_strobe_or_read_n_i,
	input  wire logic [3:0] host_data_nibble_i,
	output logic      [3:0] host_data_nibble_o,
	output logic            host_data_nibble_oe_o,
	input  wire logic       tone_valid_i,
	input  wire logic [1:0] tone_row_i,
	input  wire logic [1:0] tone_col_i,
	input  wire logic       callprog_sq_i,
	input  wire logic       tx_burst_done_i,
	output logic            early_steer_out_o,
	input  wire logic       steer_threshold_i,
	output logic            steer_in_guard_out_o,
	output logic            steer_in_guard_out_oe_o,
	output logic            irq_callprog_out_n_o,
	output logic            irq_callprog_out_n_oe_o,
	output logic      [3:0] tx_data_o,
	output logic      [3:0] ctrl_o,
	output logic            delayed_steer_o
);
	// ==========================================
	// Synchronisers
	logic [3:0] sync_s;
	logic       cs_s;
	logic       rw_s;
	logic       ds_s;
	logic       thr_s;

	tthp_sync #(.WIDTH(4)) u_sync (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.async_i    ({!chip_sel_n_i, rw_or_write_n_i, data_strobe_or_read_n_i, steer_threshold_i}),
		.sync_o     (sync_s)
	);
	// Select enters active high, so the cleared stages read as deselected
	assign {cs_s, rw_s, ds_s, thr_s} = sync_s;

	// ==========================================
	// Bus decode
	logic rd_act;
	logic wr_act;
	logic wr_act_q;
	logic rd_act_q;

	// Idle strobes outside an access do nothing since select gates them
	always_comb
	begin
		if (split_strobe_mode_i)
		begin
			rd_act = cs_s && !ds_s;
			wr_act = cs_s && !rw_s;
		end
		else
		begin
			rd_act = cs_s && ds_s && rw_s;
			wr_act = cs_s && ds_s && !rw_s;
		end
	end

	// Float rule uses raw pins so the bus releases without sync lag
	assign host_data_nibble_oe_o = split_strobe_mode_i
		? (!chip_sel_n_i && !data_strobe_or_read_n_i)
		: (!chip_sel_n_i && data_strobe_or_read_n_i && rw_or_write_n_i);

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			wr_act_q <= 1'b0;
			rd_act_q <= 1'b0;
		end
		else
		begin
			wr_act_q <= wr_act;
			rd_act_q <= rd_act;
		end
	end

	// ==========================================
	// Registers
	logic [3:0] rx_data_q;
	logic [3:0] pend_code_q;
	logic [3:0] ctrl_q;
	logic [3:0] tx_data_q;
	logic       dsteer_q;
	logic       irq_q;
	logic       rd_end;

	assign rd_end = rd_act_q && !rd_act;

	// Write taken on the synchronised leading edge: raw strobe still holds data
	// there, whereas the host may already drive new data at the trailing edge
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q    <= tthp_pkg::CTRL_RST;
			tx_data_q <= tthp_pkg::TX_DATA_RST;
		end
		else if (wr_act && !wr_act_q)
		begin
			if (register_select_i == tthp_pkg::RSEL_CTRL)
				ctrl_q <= host_data_nibble_i;
			else
				tx_data_q <= host_data_nibble_i;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			host_data_nibble_o <= 4'h0;
		else if (register_select_i == tthp_pkg::RSEL_DATA)
			host_data_nibble_o <= rx_data_q;
		else
		begin
			host_data_nibble_o <= 4'h0;
			host_data_nibble_o[tthp_pkg::STAT_DSTEER_BIT] <= dsteer_q;
			host_data_nibble_o[tthp_pkg::STAT_IRQ_BIT]    <= irq_q;
		end
	end

	// ==========================================
	// Tone code
	function automatic logic [3:0] tthp_encode(input logic [1:0] row, input logic [1:0] col);
		logic [3:0] code;
		code = 4'h0;
		if (col == 2'h3)
			code = (row == 2'h3) ? 4'h0 : 4'(4'hd + row);
		else if (row == 2'h3)
			code = (col == 2'h0) ? 4'hb : ((col == 2'h1) ? 4'ha : 4'hc);
		else
			code = 4'(row * 3 + col + 1);
		return code;
	endfunction : tthp_encode

	// ==========================================
	// Steering
	typedef enum logic [2:0] {
		TTHP_ARMED  = 3'b001,
		TTHP_SETTLE = 3'b010,
		TTHP_HELD   = 3'b100
	} tthp_steer_e;

	tthp_steer_e st_q;
	logic [$clog2(tthp_pkg::SETTLE_CYC+1)-1:0] settle_q;

	assign early_steer_out_o = tone_valid_i;

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			st_q        <= TTHP_ARMED;
			settle_q    <= '0;
			pend_code_q <= tthp_pkg::RX_DATA_RST;
			rx_data_q   <= tthp_pkg::RX_DATA_RST;
			dsteer_q    <= 1'b0;
		end
		else
		begin
			if (rd_end && register_select_i == tthp_pkg::RSEL_DATA && thr_s == 1'b0)
				dsteer_q <= 1'b0;
			case (st_q)
				TTHP_ARMED:
					if (thr_s)
					begin
						pend_code_q <= tthp_encode(tone_row_i, tone_col_i);
						settle_q    <= '0;
						st_q        <= TTHP_SETTLE;
					end
				TTHP_SETTLE:
					if (settle_q == ($bits(settle_q))'(tthp_pkg::SETTLE_CYC - 1))
					begin
						rx_data_q <= pend_code_q;
						dsteer_q  <= 1'b1;
						st_q      <= TTHP_HELD;
					end
					else
						settle_q <= settle_q + 1'b1;
				TTHP_HELD:
					if (!thr_s)
					begin
						dsteer_q <= 1'b0;
						st_q     <= TTHP_ARMED;
					end
				default:
					st_q <= TTHP_ARMED;
			endcase
		end
	end

	// Guard drives high while tone held, low after tone loss until steering re-arms, then floats
	assign steer_in_guard_out_o    = tone_valid_i;
	assign steer_in_guard_out_oe_o = (st_q != TTHP_ARMED) || tone_valid_i;

	// ==========================================
	// Interrupt / call progress
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			irq_q <= 1'b0;
		else if (tx_burst_done_i || (st_q == TTHP_SETTLE && dsteer_q == 1'b0
			&& settle_q == ($bits(settle_q))'(tthp_pkg::SETTLE_CYC - 1)))
			irq_q <= 1'b1;
		else if (rd_end && register_select_i == tthp_pkg::RSEL_CTRL)
			irq_q <= 1'b0;
	end

	// Open drain: only ever drives low
	assign irq_callprog_out_n_o = 1'b0;
	assign irq_callprog_out_n_oe_o = ctrl_q[tthp_pkg::CTRL_CP_MODE_BIT]
		? !callprog_sq_i
		: (ctrl_q[tthp_pkg::CTRL_IRQ_EN_BIT] && (irq_q || dsteer_q));

	assign tx_data_o       = tx_data_q;
	assign ctrl_o          = ctrl_q;
	assign delayed_steer_o = dsteer_q;
endmodule : tthp_host_pins

/* rtl/tthp_sync.sv */
`timescale 1ns/10ps
module tthp_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             core_clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			meta_q <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule : tthp_sync

/* shared/tthp_pkg.sv */
// Notes on behaviour
// - One register-select input chooses the register each access reaches.
// - Strobe style: direction plus data strobe; split style: write and read strobes.
// - Data bus floats when deselected, strobe low, or read strobe high.
// - Interrupt mode pulls the open-drain output low after a finished burst.
// - Call-progress mode puts the squared in-band signal on that output.
// - Early steering rises on a valid tone pair and drops on any loss.
// - Steering above threshold registers the pair and updates the latch.
// - Steering below threshold re-arms acceptance of a new pair.
// - Guard output depends on early steering and steering level.
// - Registration latches the 4-bit code, then sets delayed steering later.
// - Digits 1-9 binary, zero ten, star pound A-C eleven-fifteen, D zero.
// - Latch updates on delayed steering rise; interrupt held low while set.
package tthp_pkg;

	// ==========================================
	// Timing
	localparam int unsigned CLK_HZ            = 10_000_000;
	localparam int unsigned SETTLE_NS         = 1000;
	localparam int unsigned SETTLE_CYC_RAW    = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned SETTLE_CYC        = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;

	// ==========================================
	// Register select and reset values
	localparam logic       RSEL_DATA          = 1'b0;
	localparam logic       RSEL_CTRL          = 1'b1;
	localparam logic [3:0] RX_DATA_RST        = 4'h0;
	localparam logic [3:0] TX_DATA_RST        = 4'h0;
	localparam logic [3:0] CTRL_RST           = 4'h0;
	localparam int unsigned CTRL_IRQ_EN_BIT   = 0;
	localparam int unsigned CTRL_CP_MODE_BIT  = 1;
	localparam int unsigned STAT_DSTEER_BIT   = 0;
	localparam int unsigned STAT_IRQ_BIT      = 1;

	// ==========================================
	// Tone pair indexes: row*4+col, rows 697/770/852/941, cols 1209/1336/1477/1633
	localparam int unsigned ROWS              = 4;
	localparam int unsigned COLS              = 4;

endpackage : tthp_pkg

/* sim/tone_transceiver_host_pins_tb.sv */
`timescale 1ns/10ps
module tone_transceiver_host_pins_tb;
	logic clk = 1'b0, rst = 1'b1, split = 1'b0, tv = 1'b0, cp = 1'b0, txd = 1'b0, thr = 1'b0;
	logic cs_n, rs, rw, ds, oe, early_steer_out, gt, gt_oe, irq, irq_oe, dst;
	logic [1:0] row = 2'h0, col = 2'h0;
	logic [3:0] din, dout, txo, ctl, d;
	logic [4:0] q;
	int fail_count = 0, checks = 0;
	initial forever #50 clk = ~clk;
	tthp_host_model h (.core_clk_i(clk), .split_i(split), .rdata_i(dout), .oe_i(oe),
		.cs_n_o(cs_n), .rs_o(rs), .rw_o(rw), .ds_o(ds), .wdata_o(din));
	tthp_host_pins dut (.core_clk_i(clk), .rst_i(rst), .split_strobe_mode_i(split),
		.chip_sel_n_i(cs_n), .register_select_i(rs), .rw_or_write_n_i(rw),
		.data_strobe_or_read_n_i(ds), .host_data_nibble_i(din), .host_data_nibble_o(dout),
		.host_data_nibble_oe_o(oe), .tone_valid_i(tv), .tone_row_i(row), .tone_col_i(col),
		.callprog_sq_i(cp), .tx_burst_done_i(txd), .early_steer_out_o(early_steer_out),
		.steer_threshold_i(thr), .steer_in_guard_out_o(gt), .steer_in_guard_out_oe_o(gt_oe),
		.irq_callprog_out_n_o(irq), .irq_callprog_out_n_oe_o(irq_oe), .tx_data_o(txo),
		.ctrl_o(ctl), .delayed_steer_o(dst));
	// Keypad table, row-major: 1 2 3 A / 4 5 6 B / 7 8 9 C / star 0 pound D
	function automatic logic [3:0] code(input logic [1:0] r, input logic [1:0] c);
		logic [3:0] digit [16];
		digit = '{4'h1, 4'h2, 4'h3, 4'hd, 4'h4, 4'h5, 4'h6, 4'he,
			4'h7, 4'h8, 4'h9, 4'hf, 4'hb, 4'ha, 4'hc, 4'h0};
		return digit[{r, c}];
	endfunction : code
	task chk(input logic [4:0] seen, input logic [4:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task final_report;
		if (fail_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	// ==========================================
	// Noise on the call-progress input
	always @(posedge clk) #1 cp <= 1'($urandom);
	initial
	begin
		#(100 * 6000);
		fail_count++;
		final_report();
	end
	// ==========================================
	// Main sequence: every tone pair, bus style drawn at random for each pair
	initial
	begin
		void'($urandom(32'h04b4));
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		chk(5'(txo), 5'h0);
		chk(5'(dst), 5'h0);
		for (int i = 0; i < 16; i++)
		begin
			#1 split = 1'($urandom);
			d = 4'($urandom);
			h.acc(1'b0, 1'b1, d, q);
			chk(5'(txo), 5'(d));
			h.acc(1'b1, 1'b1, 4'h1, q);
			chk(5'(ctl), 5'h1);
			#1 tv = 1'b1;
			row = 2'(i >> 2);
			col = 2'(i);
			repeat (5) @(posedge clk);
			chk(5'(early_steer_out), 5'h1);
			#1 thr = 1'b1;
			for (int k = 0; k < 40 && dst !== 1'b1; k++) @(posedge clk);
			chk(5'(dst), 5'h1);
			chk(5'({gt_oe, gt}), 5'h3);
			h.acc(1'b1, 1'b0, 4'h0, q);
			chk({q[4], 2'h0, q[1:0]}, 5'h13);
			h.acc(1'b0, 1'b0, 4'h0, q);
			chk(q, {1'b1, code(row, col)});
			#1 tv = 1'b0;
			txd = 1'b1;
			@(posedge clk);
			#1 txd = 1'b0;
			thr = 1'b0;
			repeat (8) @(posedge clk);
			chk({early_steer_out, 3'h0, dst}, 5'h0);
			chk(5'({gt_oe, gt}), 5'h0);
			chk(5'(irq_oe), 5'h1);
			// Call-progress mode: pin follows the squared signal
			h.acc(1'b1, 1'b1, 4'h2, q);
			chk(5'(ctl), 5'h2);
			repeat (4)
			begin
				@(posedge clk);
				chk(5'(irq_oe), 5'(!cp));
			end
		end
		final_report();
	end
endmodule : tone_transceiver_host_pins_tb

/* sim/tthp_host_model.sv */
`timescale 1ns/10ps
// ==========================================
// Host on the nibble bus
module tthp_host_model (
	input  wire logic       core_clk_i,
	input  wire logic       split_i,
	input  wire logic [3:0] rdata_i,
	input  wire logic       oe_i,
	output logic            cs_n_o,
	output logic            rs_o,
	output logic            rw_o,
	output logic            ds_o,
	output logic      [3:0] wdata_o
);
	logic act = 1'b0;
	logic wr  = 1'b0;
	initial rs_o = 1'b0;
	initial wdata_o = 4'h0;
	assign cs_n_o = !act;
	assign rw_o   = split_i ? !(act && wr) : !wr;
	assign ds_o   = split_i ? !(act && !wr) : act;
	// Strobes held 4 cycles, gap 3, as the synchronisers need
	task acc(input logic rs, input logic w, input logic [3:0] d, output logic [4:0] q);
		@(posedge core_clk_i);
		#1 act = 1'b1;
		wr = w;
		rs_o = rs;
		wdata_o = d;
		repeat (4) @(posedge core_clk_i);
		q = {oe_i, rdata_i};
		#1 act = 1'b0;
		wdata_o = ~d;
		repeat (3) @(posedge core_clk_i);
	endtask : acc
endmodule : tthp_host_model

/* sim/tthp_host_pins_properties.sv */
`timescale 1ns/10ps
// ==========================================
// Pin-level checks
module tthp_host_pins_chk (
	input wire logic       core_clk_i,
	input wire logic       rst_i,
	input wire logic       split_strobe_mode_i,
	input wire logic       chip_sel_n_i,
	input wire logic       rw_or_write_n_i,
	input wire logic       data_strobe_or_read_n_i,
	input wire logic       host_data_nibble_oe_o,
	input wire logic       tone_valid_i,
	input wire logic       early_steer_out_o,
	input wire logic       steer_threshold_i,
	input wire logic       steer_in_guard_out_o,
	input wire logic       steer_in_guard_out_oe_o,
	input wire logic       irq_callprog_out_n_o,
	input wire logic       irq_callprog_out_n_oe_o,
	input wire logic [3:0] ctrl_o,
	input wire logic       delayed_steer_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	property p_hiz_cs; chip_sel_n_i |-> !host_data_nibble_oe_o; endproperty
	a_hiz_cs: assert property (p_hiz_cs) else $error("bus driven while deselected");
	property p_hiz_st; !split_strobe_mode_i && !data_strobe_or_read_n_i |-> !host_data_nibble_oe_o;
	endproperty
	a_hiz_st: assert property (p_hiz_st) else $error("bus driven with strobe low");
	property p_hiz_sp; split_strobe_mode_i && data_strobe_or_read_n_i |-> !host_data_nibble_oe_o;
	endproperty
	a_hiz_sp: assert property (p_hiz_sp) else $error("bus driven with read high");
	property p_rd_drv; !chip_sel_n_i && (split_strobe_mode_i ? !data_strobe_or_read_n_i
		: (data_strobe_or_read_n_i && rw_or_write_n_i)) |-> host_data_nibble_oe_o; endproperty
	a_rd_drv: assert property (p_rd_drv) else $error("read not driven");
	property p_est; early_steer_out_o == tone_valid_i; endproperty
	a_est: assert property (p_est) else $error("early steering wrong");
	property p_od; irq_callprog_out_n_o == 1'b0; endproperty
	a_od: assert property (p_od) else $error("open drain drives high");
	property p_gt; steer_in_guard_out_oe_o |-> steer_in_guard_out_o == tone_valid_i; endproperty
	a_gt: assert property (p_gt) else $error("guard output wrong");
	property p_ds_thr; $rose(delayed_steer_o) |-> $past(steer_threshold_i, 3); endproperty
	a_ds_thr: assert property (p_ds_thr) else $error("steer flag without threshold");
	property p_ds_clr; !steer_threshold_i [*5] |-> !delayed_steer_o; endproperty
	a_ds_clr: assert property (p_ds_clr) else $error("steer flag not cleared");
	property p_irq; $rose(delayed_steer_o) && ctrl_o[0] && !ctrl_o[1]
		|-> ##[0:2] irq_callprog_out_n_oe_o; endproperty
	a_irq: assert property (p_irq) else $error("interrupt not pulled low");
endmodule : tthp_host_pins_chk

bind tthp_host_pins tthp_host_pins_chk u_chk (.*);
